// ---- hdl/asc_cfg_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface asc_cfg_if;
  logic req;
  logic we;
  logic [asc_pkg::AW-1:0] addr;
  logic [asc_pkg::DW-1:0] wdata;
  logic ack;
  logic [asc_pkg::DW-1:0] rdata;
  logic single_ended_sync_in;
  logic timestamp_diff_in;

  modport dev (
    input req, we, addr, wdata, single_ended_sync_in, timestamp_diff_in,
    output ack, rdata
  );

  modport host (
    output req, we, addr, wdata, single_ended_sync_in, timestamp_diff_in,
    input ack, rdata
  );
endinterface

`default_nettype wire

// ---- hdl/asc_dev.sv ----
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Host resets or powers device before configuring
// - Host applies stable sampling clock first
// - Link enable zero halts output link machine
// - Calibration enable zero halts calibration machine
// - Host programs output bus mode while halted
// - Sync source selects single-ended or timestamp
// - Host picks calibration mode and offset
// - Calibration enable one restarts calibration machine
// - Host may then enable overrange detection
// - Link enable one starts link, receiver trains
// - Sync on running link emits strobe/pattern
// - Trigger zero then one starts calibration run
// - Dual-edge enable one selects single-channel mode
// - Demux one spreads data over four buses
// - Alignment zero gives staggered bus updates
// - Channel mode change needs no clock change
// - Soft reset bit returns device to reset
module asc_dev (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  asc_cfg_if.dev ifc,
  input wire logic [asc_pkg::SW-1:0] i_samp_a,
  input wire logic [asc_pkg::SW-1:0] i_samp_b,
  output logic [4*asc_pkg::SW-1:0] o_bus,
  output logic [3:0] o_strobe,
  output logic o_overrange,
  output logic o_link_up,
  output logic o_cal_busy
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic link_en;
    logic [2:0] out_mode;
    logic sync_sel;
    logic cal_en;
    logic [1:0] cal_cfg;
    logic trig;
    logic overrange_enable;
    logic [11:0] ovr_thr;
    logic des;
    logic [11:0] pat;
    asc_pkg::asc_link_t lk;
    logic [7:0] lk_cnt;
    asc_pkg::asc_cal_t cl;
    logic [7:0] cl_cnt;
    logic cal_done;
    logic sync_d;
    logic [7:0] pat_cnt;
    logic [1:0] stb_cnt;
    logic phase;
    logic [11:0] pa;
    logic [11:0] pb;
    logic ack;
    logic [15:0] rdata;
    logic [47:0] bus;
    logic [3:0] stb;
    logic ovr;
    logic link_up;
    logic cal_busy;
  } asc_dev_st_t;

  localparam asc_dev_st_t RST_ST = '{
    out_mode: asc_pkg::RST_OUT_MODE,
    ovr_thr: asc_pkg::RST_OVR_THR,
    pat: asc_pkg::RST_PAT,
    lk: asc_pkg::LK_OFF,
    cl: asc_pkg::CL_IDLE,
    default: '0
  };

  asc_dev_st_t s;
  asc_dev_st_t n;
  logic wr;
  logic sync_now;
  logic sync_rise;
  logic trig_rise;
  logic [7:0] cal_len;

  // ==========================================================
  // Read decode
  // ==========================================================
  function automatic logic [15:0] rd(input asc_dev_st_t st, input logic [7:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      asc_pkg::A_LINK: v[0] = st.link_en;
      asc_pkg::A_OUTMODE: v[2:0] = st.out_mode;
      asc_pkg::A_SYNC: v[0] = st.sync_sel;
      asc_pkg::A_CALEN: v[0] = st.cal_en;
      asc_pkg::A_CALCFG: v[1:0] = st.cal_cfg;
      asc_pkg::A_CALTRIG: v[0] = st.trig;
      asc_pkg::A_OVR: v[0] = st.overrange_enable;
      asc_pkg::A_OVRTHR: v[11:0] = st.ovr_thr;
      asc_pkg::A_CHAN: v[0] = st.des;
      asc_pkg::A_PAT: v[11:0] = st.pat;
      asc_pkg::A_STATUS: begin
        v[asc_pkg::B_ST_LINK] = st.link_up;
        v[asc_pkg::B_ST_CALBUSY] = st.cal_busy;
        v[asc_pkg::B_ST_CALDONE] = st.cal_done;
        v[asc_pkg::B_ST_OVR] = st.ovr;
      end
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // Settings that shape the link may only change while the link is halted,
  // and calibration settings only while calibration is halted. A write that
  // breaks this is acknowledged but leaves the register as it was.
  function automatic logic wr_ok(input asc_dev_st_t st, input logic [7:0] a);
    logic ok;
    ok = 1'b1;
    case (a)
      asc_pkg::A_OUTMODE, asc_pkg::A_SYNC, asc_pkg::A_PAT: ok = !st.link_en;
      asc_pkg::A_CALCFG: ok = !st.cal_en;
      asc_pkg::A_CHAN: ok = !st.link_en && !st.cal_en;
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    n = s;
    wr = ifc.req & ~s.ack & ifc.we;
    sync_now = s.sync_sel ? ifc.timestamp_diff_in : ifc.single_ended_sync_in;
    sync_rise = sync_now & ~s.sync_d;
    n.sync_d = sync_now;
    n.ack = ifc.req & ~s.ack;
    n.rdata = (ifc.req & ~s.ack & ~ifc.we) ? rd(s, ifc.addr) : s.rdata;

    if (wr && wr_ok(s, ifc.addr)) begin
      case (ifc.addr)
        asc_pkg::A_LINK: n.link_en = ifc.wdata[0];
        asc_pkg::A_OUTMODE: n.out_mode = ifc.wdata[2:0];
        asc_pkg::A_SYNC: n.sync_sel = ifc.wdata[0];
        asc_pkg::A_CALEN: n.cal_en = ifc.wdata[0];
        asc_pkg::A_CALCFG: n.cal_cfg = ifc.wdata[1:0];
        asc_pkg::A_CALTRIG: n.trig = ifc.wdata[0];
        asc_pkg::A_OVR: n.overrange_enable = ifc.wdata[0];
        asc_pkg::A_OVRTHR: n.ovr_thr = ifc.wdata[11:0];
        asc_pkg::A_CHAN: n.des = ifc.wdata[0];
        asc_pkg::A_PAT: n.pat = ifc.wdata[11:0];
        default: n.link_en = n.link_en;
      endcase
    end

    // Calibration machine.
    trig_rise = n.trig & ~s.trig;
    cal_len = s.cal_cfg[asc_pkg::B_CAL_OFS] ?
      8'(asc_pkg::CAL_RUN_CYC + asc_pkg::CAL_OFS_CYC) : asc_pkg::CAL_RUN_CYC;
    case (s.cl)
      asc_pkg::CL_IDLE: begin
        if (n.cal_en && trig_rise) begin
          n.cl = asc_pkg::CL_RUN;
          n.cl_cnt = cal_len - 8'h01;
          n.cal_done = 1'b0;
        end
      end
      asc_pkg::CL_RUN: begin
        if (s.cl_cnt == 8'h00) begin
          n.cl = asc_pkg::CL_DONE;
          n.cal_done = 1'b1;
        end else begin
          n.cl_cnt = s.cl_cnt - 8'h01;
        end
      end
      asc_pkg::CL_DONE: begin
        // Background mode keeps re-running; foreground waits for a trigger.
        if (s.cal_cfg[asc_pkg::B_CAL_BG] || trig_rise) begin
          n.cl = asc_pkg::CL_RUN;
          n.cl_cnt = cal_len - 8'h01;
        end
      end
      default: n.cl = asc_pkg::CL_IDLE;
    endcase
    if (!n.cal_en) begin
      n.cl = (s.cl == asc_pkg::CL_DONE) ? asc_pkg::CL_DONE : asc_pkg::CL_IDLE;
    end
    n.cal_busy = (n.cl == asc_pkg::CL_RUN);

    // Output link machine.
    case (s.lk)
      asc_pkg::LK_OFF: begin
        if (n.link_en) begin
          n.lk = asc_pkg::LK_INIT;
          n.lk_cnt = asc_pkg::LINK_INIT_CYC - 8'h01;
        end
      end
      asc_pkg::LK_INIT: begin
        if (s.lk_cnt == 8'h00) begin
          n.lk = asc_pkg::LK_RUN;
        end else begin
          n.lk_cnt = s.lk_cnt - 8'h01;
        end
      end
      asc_pkg::LK_RUN: n.lk = asc_pkg::LK_RUN;
      default: n.lk = asc_pkg::LK_OFF;
    endcase
    if (!n.link_en) begin
      n.lk = asc_pkg::LK_OFF;
    end
    n.link_up = (n.lk == asc_pkg::LK_RUN);

    // Data path. Samples a and b are the two channels in dual-channel mode
    // and the rising/falling edge samples of one channel in dual-edge mode,
    // so the lane map is the same and the clock rate never changes.
    n.phase = ~s.phase;
    n.pa = i_samp_a;
    n.pb = i_samp_b;
    n.stb = 4'h0;
    n.bus = 48'h0;
    n.ovr = s.overrange_enable && ((i_samp_a >= s.ovr_thr) || (i_samp_b >= s.ovr_thr));
    if (s.lk == asc_pkg::LK_INIT) begin
      // Training: toggling strobes give the receiver an edge to lock onto.
      n.stb = {4{s.phase}};
    end else if (s.lk == asc_pkg::LK_RUN) begin
      if (sync_rise) begin
        n.stb_cnt = 2'h0;
        if (s.out_mode[asc_pkg::B_PATSYNC]) begin
          n.pat_cnt = asc_pkg::SYNC_PAT_CYC;
        end
      end else begin
        n.stb_cnt = s.stb_cnt + 2'h1;
      end
      n.stb = (s.stb_cnt == 2'h0) ? 4'hF : 4'h0;
      if (!s.out_mode[asc_pkg::B_DEMUX]) begin
        n.bus = {24'h0, i_samp_b, i_samp_a};
      end else if (s.out_mode[asc_pkg::B_ALIGN]) begin
        n.bus = s.phase ? {i_samp_b, i_samp_a, s.pb, s.pa} : s.bus;
      end else begin
        n.bus = s.bus;
        if (s.phase) begin
          n.bus[47:24] = {i_samp_b, i_samp_a};
        end else begin
          n.bus[23:0] = {i_samp_b, i_samp_a};
        end
      end
      if (s.pat_cnt != 8'h00) begin
        n.bus = {4{s.pat}};
        n.pat_cnt = s.pat_cnt - 8'h01;
      end
    end

    // Soft reset restores every setting; the bus answer and last read data survive.
    if (wr && ifc.addr == asc_pkg::A_CONFIG && ifc.wdata[asc_pkg::B_SOFT_RST]) begin
      n = RST_ST;
      n.ack = 1'b1;
      n.rdata = s.rdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= RST_ST;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign ifc.ack = s.ack;
  assign ifc.rdata = s.rdata;
  assign o_bus = s.bus;
  assign o_strobe = s.stb;
  assign o_overrange = s.ovr;
  assign o_link_up = s.link_up;
  assign o_cal_busy = s.cal_busy;

endmodule // asc_dev

`default_nettype wire

// ---- hdl/asc_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module asc_host (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_dev_clk_ok,
  asc_cfg_if.host ifc
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic busy;
    logic auto_run;
    logic [3:0] step;
    asc_pkg::asc_hseq_t hs;
    logic sync_se;
    logic sync_ts;
    logic [7:0] setup;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } asc_host_st_t;

  asc_host_st_t s;
  asc_host_st_t n;
  logic acc;
  logic [2:0] clk_ok_sync;

  // Startup order: reset, halt link, halt calibration, program settings,
  // re-enable calibration, overrange, link, then trigger low and high.
  function automatic logic [23:0] seq_cmd(input logic [3:0] st, input logic [7:0] su);
    logic [23:0] c;
    c = 24'h0;
    case (st)
      4'h0: c = {asc_pkg::A_CONFIG, 16'h0001};
      4'h1: c = {asc_pkg::A_LINK, 16'h0000};
      4'h2: c = {asc_pkg::A_CALEN, 16'h0000};
      4'h3: c = {asc_pkg::A_OUTMODE, 13'h0, su[2:0]};
      4'h4: c = {asc_pkg::A_CHAN, 15'h0, su[3]};
      4'h5: c = {asc_pkg::A_SYNC, 15'h0, su[4]};
      4'h6: c = {asc_pkg::A_CALCFG, 14'h0, su[6:5]};
      4'h7: c = {asc_pkg::A_CALEN, 16'h0001};
      4'h8: c = {asc_pkg::A_OVR, 15'h0, su[7]};
      4'h9: c = {asc_pkg::A_LINK, 16'h0001};
      4'hA: c = {asc_pkg::A_CALTRIG, 16'h0000};
      4'hB: c = {asc_pkg::A_CALTRIG, 16'h0001};
      default: c = 24'h0;
    endcase
    return c;
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    n = s;
    acc = i_psel & i_penable & ~s.pready;
    n.pready = acc;
    n.pslverr = 1'b0;
    if (acc && i_pwrite) begin
      case (i_paddr)
        asc_pkg::HA_CMD: begin
          if (s.busy) begin
            n.pslverr = 1'b1;
          end else begin
            n.we = i_pwdata[asc_pkg::B_CMD_WE];
            n.addr = i_pwdata[23:16];
            n.wdata = i_pwdata[15:0];
            n.hs = asc_pkg::HS_NEXT;
            n.busy = 1'b1;
          end
        end
        asc_pkg::HA_SYNC: begin
          n.sync_se = i_pwdata[0];
          n.sync_ts = i_pwdata[1];
        end
        asc_pkg::HA_SETUP: n.setup = i_pwdata[7:0];
        asc_pkg::HA_START: begin
          if (s.busy || !i_pwdata[0]) begin
            n.pslverr = s.busy;
          end else begin
            n.auto_run = 1'b1;
            n.step = 4'h0;
            n.busy = 1'b1;
            n.hs = asc_pkg::HS_NEXT;
          end
        end
        default: n.pslverr = 1'b1;
      endcase
    end else if (acc) begin
      case (i_paddr)
        asc_pkg::HA_STAT: n.prdata = {s.rdata, 14'h0, s.auto_run, s.busy};
        asc_pkg::HA_SYNC: n.prdata = {30'h0, s.sync_ts, s.sync_se};
        asc_pkg::HA_SETUP: n.prdata = {24'h0, s.setup};
        default: begin
          n.prdata = 32'h0;
          n.pslverr = (i_paddr != asc_pkg::HA_CMD) && (i_paddr != asc_pkg::HA_START);
        end
      endcase
    end

    case (s.hs)
      asc_pkg::HS_IDLE: n.busy = n.busy;
      asc_pkg::HS_NEXT: begin
        if (s.auto_run) begin
          n.we = 1'b1;
          {n.addr, n.wdata} = seq_cmd(s.step, s.setup);
        end
        n.req = 1'b1;
        n.hs = asc_pkg::HS_REQ;
      end
      asc_pkg::HS_REQ: begin
        if (ifc.ack) begin
          n.req = 1'b0;
          n.rdata = ifc.rdata;
          if (!s.auto_run || s.step == asc_pkg::SEQ_LAST) begin
            n.hs = asc_pkg::HS_IDLE;
            n.busy = 1'b0;
            n.auto_run = 1'b0;
          end else begin
            n.step = s.step + 4'h1;
            n.hs = (s.step == 4'h0) ? asc_pkg::HS_WCLK : asc_pkg::HS_NEXT;
          end
        end
      end
      asc_pkg::HS_WCLK: begin
        if (clk_ok_sync[2]) begin
          n.hs = asc_pkg::HS_NEXT;
        end
      end
      default: n.hs = asc_pkg::HS_IDLE;
    endcase
  end

  // The clock-good level comes from outside this clock's domain.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_ok_sync <= 3'h0;
    end else begin
      clk_ok_sync <= {clk_ok_sync[1:0], i_dev_clk_ok};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{hs: asc_pkg::HS_IDLE, default: '0};
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign o_prdata = s.prdata;
  assign o_pready = s.pready;
  assign o_pslverr = s.pslverr;
  assign ifc.req = s.req;
  assign ifc.we = s.we;
  assign ifc.addr = s.addr;
  assign ifc.wdata = s.wdata;
  assign ifc.single_ended_sync_in = s.sync_se;
  assign ifc.timestamp_diff_in = s.sync_ts;

endmodule // asc_host

`default_nettype wire

// ---- hdl/asc_pkg.sv ----
package asc_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int AW = 8;
  localparam int DW = 16;
  localparam int SW = 12;

  // ==========================================================
  // Device register map (word index on the control port)
  // ==========================================================
  localparam logic [7:0] A_CONFIG = 8'h00;
  localparam logic [7:0] A_LINK = 8'h01;
  localparam logic [7:0] A_OUTMODE = 8'h02;
  localparam logic [7:0] A_SYNC = 8'h03;
  localparam logic [7:0] A_CALEN = 8'h04;
  localparam logic [7:0] A_CALCFG = 8'h05;
  localparam logic [7:0] A_CALTRIG = 8'h06;
  localparam logic [7:0] A_OVR = 8'h07;
  localparam logic [7:0] A_OVRTHR = 8'h08;
  localparam logic [7:0] A_CHAN = 8'h09;
  localparam logic [7:0] A_PAT = 8'h0A;
  localparam logic [7:0] A_STATUS = 8'h0B;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int B_SOFT_RST = 0;
  localparam int B_DEMUX = 0;
  localparam int B_ALIGN = 1;
  localparam int B_PATSYNC = 2;
  localparam int B_CAL_BG = 0;
  localparam int B_CAL_OFS = 1;
  localparam int B_ST_LINK = 0;
  localparam int B_ST_CALBUSY = 1;
  localparam int B_ST_CALDONE = 2;
  localparam int B_ST_OVR = 3;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [11:0] RST_OVR_THR = 12'hFC0;
  localparam logic [11:0] RST_PAT = 12'hA5A;
  localparam logic [2:0] RST_OUT_MODE = 3'h0;

  // ==========================================================
  // Cycle counts
  // ==========================================================
  localparam logic [7:0] LINK_INIT_CYC = 8'h10;
  localparam logic [7:0] CAL_RUN_CYC = 8'h40;
  localparam logic [7:0] CAL_OFS_CYC = 8'h20;
  localparam logic [7:0] SYNC_PAT_CYC = 8'h08;

  // ==========================================================
  // State encodings
  // ==========================================================
  typedef enum logic [1:0] {
    LK_OFF = 2'b00,
    LK_INIT = 2'b01,
    LK_RUN = 2'b11
  } asc_link_t;

  typedef enum logic [1:0] {
    CL_IDLE = 2'b00,
    CL_RUN = 2'b01,
    CL_DONE = 2'b11
  } asc_cal_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_REQ = 2'b01,
    HS_NEXT = 2'b11,
    HS_WCLK = 2'b10
  } asc_hseq_t;

  // ==========================================================
  // Host APB map and startup sequence
  // ==========================================================
  localparam logic [7:0] HA_CMD = 8'h00;
  localparam logic [7:0] HA_STAT = 8'h04;
  localparam logic [7:0] HA_SYNC = 8'h08;
  localparam logic [7:0] HA_SETUP = 8'h0C;
  localparam logic [7:0] HA_START = 8'h10;
  localparam int B_CMD_WE = 31;
  localparam logic [3:0] SEQ_LAST = 4'hB;

endpackage

// ---- verif/adc_startup_config_sequence_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module adc_startup_config_sequence_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic clk_ok = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, seen, ovr, link_up, cal_busy;
  logic [47:0] bus;
  logic [3:0] strobe;
  int fails = 0;
  int compares = 0;
  int k = 0;

  asc_cfg_if ifc();
  asc_host asc_host_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_dev_clk_ok(clk_ok), .ifc(ifc));
  asc_dev asc_dev_i (.i_ref_clk(clk), .i_rst_n(rst_n), .ifc(ifc), .i_samp_a(12'h123),
    .i_samp_b(12'h456), .o_bus(bus), .o_strobe(strobe), .o_overrange(ovr),
    .o_link_up(link_up), .o_cal_busy(cal_busy));
  asc_assertions asc_assertions_i (.i_ref_clk(clk), .i_rst_n(rst_n), .req(ifc.req),
    .we(ifc.we), .addr(ifc.addr), .wdata(ifc.wdata), .ack(ifc.ack), .rdata(ifc.rdata),
    .o_link_up(link_up), .o_cal_busy(cal_busy));

  always #2 clk = ~clk;

  // ==========================================================
  // Tasks
  // ==========================================================
  task check(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task report_and_stop;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      report_and_stop;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // The host may still be waiting for the clock, so polling is bounded.
  task wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, asc_pkg::HA_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    if (rd[0] !== 1'b0) begin
      fails++;
      report_and_stop;
    end
  endtask

  task cmd(input logic w, input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, asc_pkg::HA_CMD, {w, 7'h00, a, d});
    wait_idle;
  endtask

  task wait_up;
    int n;
    for (n = 0; n < 40 && link_up !== 1'b1; n++) @(posedge clk);
    if (link_up !== 1'b1) begin
      fails++;
      report_and_stop;
    end
  endtask

  task poll_pat;
    int n;
    seen = 1'b0;
    for (n = 0; n < 12; n++) begin
      @(posedge clk);
      if (bus === {4{asc_pkg::RST_PAT}}) seen = 1'b1;
    end
  endtask

  // ==========================================================
  // Sequence of tests
  // ==========================================================
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, asc_pkg::HA_STAT, 32'h0);
    check(rd, 48'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({err, rd}, {15'h0, 1'b1, 32'h0});
    cmd(1'b0, asc_pkg::A_OVRTHR, 16'h0);
    check(rd[31:16], {4'h0, asc_pkg::RST_OVR_THR});
    $display("test reset done");
    apb(1'b1, asc_pkg::HA_SETUP, 32'h8D);
    apb(1'b1, asc_pkg::HA_START, 32'h1);
    repeat (30) @(posedge clk);
    apb(1'b0, asc_pkg::HA_STAT, 32'h0);
    check(rd[0], 1'b1);
    apb(1'b1, asc_pkg::HA_CMD, 32'h0);
    check(err, 1'b1);
    clk_ok <= 1'b1;
    wait_idle;
    check(cal_busy, 1'b1);
    wait_up;
    check(link_up, 1'b1);
    cmd(1'b0, asc_pkg::A_OUTMODE, 16'h0);
    check(rd[31:16], 16'h5);
    cmd(1'b1, asc_pkg::A_CHAN, 16'h0);
    cmd(1'b0, asc_pkg::A_CHAN, 16'h0);
    check(rd[31:16], 16'h1);
    k = 0;
    repeat (8) begin
      @(posedge clk);
      if (strobe === 4'hF) k++;
    end
    check(k, 2);
    cmd(1'b1, asc_pkg::A_CALCFG, 16'h3);
    cmd(1'b0, asc_pkg::A_CALCFG, 16'h0);
    check(rd[31:16], 16'h0);
    for (int n = 0; n < 150 && cal_busy !== 1'b0; n++) @(posedge clk);
    if (cal_busy !== 1'b0) begin
      fails++;
      report_and_stop;
    end
    cmd(1'b0, asc_pkg::A_STATUS, 16'h0);
    check(rd[31:16], 16'h5);
    $display("test startup done");
    cmd(1'b1, asc_pkg::A_CALTRIG, 16'h1);
    repeat (4) @(posedge clk);
    check(cal_busy, 1'b0);
    cmd(1'b1, asc_pkg::A_CALTRIG, 16'h0);
    cmd(1'b1, asc_pkg::A_CALTRIG, 16'h1);
    check(cal_busy, 1'b1);
    cmd(1'b1, asc_pkg::A_CALEN, 16'h0);
    check(cal_busy, 1'b0);
    cmd(1'b1, asc_pkg::A_CALCFG, 16'h2);
    cmd(1'b0, asc_pkg::A_CALCFG, 16'h0);
    check(rd[31:16], 16'h2);
    cmd(1'b1, asc_pkg::A_OVRTHR, 16'h100);
    repeat (3) @(posedge clk);
    check(ovr, 1'b1);
    $display("test calibration done");
    apb(1'b1, asc_pkg::HA_SYNC, 32'h2);
    poll_pat;
    check(seen, 1'b0);
    apb(1'b1, asc_pkg::HA_SYNC, 32'h1);
    poll_pat;
    check(seen, 1'b1);
    apb(1'b1, asc_pkg::HA_SYNC, 32'h0);
    repeat (12) @(posedge clk);
    check(bus, {12'h456, 12'h123, 12'h456, 12'h123});
    $display("test sync done");
    cmd(1'b1, asc_pkg::A_OUTMODE, 16'h0);
    cmd(1'b0, asc_pkg::A_OUTMODE, 16'h0);
    check(rd[31:16], 16'h5);
    cmd(1'b1, asc_pkg::A_LINK, 16'h0);
    check(link_up, 1'b0);
    cmd(1'b1, asc_pkg::A_OUTMODE, 16'h4);
    cmd(1'b1, asc_pkg::A_SYNC, 16'h1);
    cmd(1'b1, asc_pkg::A_LINK, 16'h1);
    wait_up;
    apb(1'b1, asc_pkg::HA_SYNC, 32'h2);
    poll_pat;
    check(seen, 1'b1);
    repeat (12) @(posedge clk);
    check(bus, {24'h0, 12'h456, 12'h123});
    $display("test relink done");
    cmd(1'b1, asc_pkg::A_CONFIG, 16'h1);
    check(link_up, 1'b0);
    cmd(1'b0, asc_pkg::A_OUTMODE, 16'h0);
    check(rd[31:16], 16'h0);
    $display("test soft reset done");
    report_and_stop;
  end
endmodule // adc_startup_config_sequence_tb

`default_nettype wire

// ---- verif/asc_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module asc_assertions (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [asc_pkg::AW-1:0] addr,
  input wire logic [asc_pkg::DW-1:0] wdata,
  input wire logic ack,
  input wire logic [asc_pkg::DW-1:0] rdata,
  input wire logic o_link_up,
  input wire logic o_cal_busy
);
  // ==========================================================
  // Shadow of the calibration enable and trigger, built from acknowledged writes
  // ==========================================================
  logic cal_en_q;
  logic trig_q;
  logic wr_ack;
  assign wr_ack = req && we && ack;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cal_en_q <= 1'b0;
      trig_q <= 1'b0;
    end else if (wr_ack && addr == asc_pkg::A_CONFIG && wdata[0]) begin
      cal_en_q <= 1'b0;
      trig_q <= 1'b0;
    end else if (wr_ack && addr == asc_pkg::A_CALEN) begin
      cal_en_q <= wdata[0];
    end else if (wr_ack && addr == asc_pkg::A_CALTRIG) begin
      trig_q <= wdata[0];
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // ==========================================================
  // Link handshake and startup behaviour
  // ==========================================================
  // Training must last a while before the link reports up.
  sequence link_train_s;
    !o_link_up [*8] ##[1:16] o_link_up;
  endsequence

  sequence trig_rise_s;
    wr_ack && addr == asc_pkg::A_CALTRIG && wdata[0] && !trig_q;
  endsequence

  req_hold_a: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
    else $error("request changed before it was answered");
  req_answer_a: assert property ($rose(req) |=> ack)
    else $error("request not answered in one cycle");
  ack_pulse_a: assert property (ack |=> !ack && !req)
    else $error("answer longer than one cycle or request kept");
  ack_cause_a: assert property (ack |-> $past(req))
    else $error("answer without request");
  rdata_hold_a: assert property (!(ack && !we) |-> $stable(rdata))
    else $error("read data moved without a read");
  link_halt_a: assert property (wr_ack && addr == asc_pkg::A_LINK && !wdata[0] |-> ##[1:3] !o_link_up)
    else $error("link still up after disable");
  cal_halt_a: assert property (wr_ack && addr == asc_pkg::A_CALEN && !wdata[0] |-> ##[1:3] !o_cal_busy)
    else $error("calibration still busy after disable");
  link_start_a: assert property (wr_ack && addr == asc_pkg::A_LINK && wdata[0] && !o_link_up |=> link_train_s)
    else $error("link training length wrong");
  cal_start_a: assert property (trig_rise_s and cal_en_q |-> ##[1:4] o_cal_busy)
    else $error("trigger rise did not start calibration");
  trig_hold_a: assert property (wr_ack && addr == asc_pkg::A_CALTRIG && wdata[0] && trig_q && !o_cal_busy |=> !o_cal_busy [*4])
    else $error("held trigger started calibration");
endmodule // asc_assertions

`default_nettype wire
